// [core/rfc_ctrl.sv]
// Receive FIFO control and status for four ports
`timescale 1ns/100ps
module rfc_ctrl (
    // Clock and reset
    input  wire logic                                       mclk,
    input  wire logic                                       nrst,
    // Register port
    input  wire logic [rfc_pkg::ADDR_W-1:0]                 reg_addr,
    input  wire logic [rfc_pkg::REG_W-1:0]                  reg_wdata,
    input  wire logic                                       reg_wr,
    input  wire logic                                       reg_rd,
    output logic      [rfc_pkg::REG_W-1:0]                  reg_rdata,
    // Operating modes
    input  wire logic                                       cell_mode,
    input  wire logic                                       level2_mode,
    // Line side, one lane per port
    input  wire logic [rfc_pkg::NUM_PORTS-1:0]              line_valid,
    output logic      [rfc_pkg::NUM_PORTS-1:0]              line_ready,
    input  wire logic [rfc_pkg::NUM_PORTS-1:0]
                      [rfc_pkg::DATA_W-1:0]                 line_data,
    input  wire logic [rfc_pkg::NUM_PORTS-1:0]              line_sop,
    input  wire logic [rfc_pkg::NUM_PORTS-1:0]              line_eop,
    input  wire logic [rfc_pkg::NUM_PORTS-1:0]              line_abort,
    input  wire logic [rfc_pkg::NUM_PORTS-1:0]
                      [rfc_pkg::BYTES_W-1:0]                line_bytes,
    // System interface pins
    input  wire logic [rfc_pkg::REG_W-1:0]                  poll_address_bus,
    input  wire logic                                       read_enable_n,
    input  wire logic                                       read_start_strobe,
    output logic                                            poll_status,
    output logic      [rfc_pkg::DATA_W-1:0]                 read_data_bus,
    output logic                                            read_valid,
    output logic                                            read_sop,
    output logic                                            read_eop,
    // Per-port status
    output logic      [rfc_pkg::NUM_PORTS-1:0]        rx_cell_packet_available,
    output logic      [rfc_pkg::NUM_PORTS-1:0]              almost_full,
    output logic      [rfc_pkg::NUM_PORTS-1:0]              almost_empty,
    output logic      [rfc_pkg::NUM_PORTS-1:0]              ram_powerdown,
    output logic      [rfc_pkg::NUM_PORTS-1:0]              fifo_irq
);
    localparam int NP = rfc_pkg::NUM_PORTS;
    localparam int DW = rfc_pkg::DATA_W;
    localparam int TW = rfc_pkg::THR_W;
    localparam int LW = rfc_pkg::LEVEL_W;
    localparam int PORT_W_L = rfc_pkg::PORT_W;
    localparam logic [rfc_pkg::SYNC_W-1:0] PIN_IDLE =
        {1'b1, {(rfc_pkg::SYNC_W-1){1'b0}}};

    // Pin synchroniser: address, enable and strobe
    logic [rfc_pkg::SYNC_W-1:0] s1_r;
    logic [rfc_pkg::SYNC_W-1:0] s2_r;
    logic [rfc_pkg::SYNC_W-1:0] s3_r;
    logic [rfc_pkg::SYNC_W-1:0] pin_r;
    logic [rfc_pkg::SYNC_W-1:0] pin_nxt;
    logic [rfc_pkg::REG_W-1:0]  sys_addr;
    logic                       sys_ren_n;
    logic                       sys_strobe;
    logic                       sel_evt;

    // Register decode
    logic [PORT_W_L-1:0]        reg_port;
    logic [rfc_pkg::ADDR_W-1:0] reg_local;

    // Per-port arrays, then register and read-bus next values
    logic [NP-1:0][rfc_pkg::REG_W-1:0] port_rdata;
    logic [NP-1:0][rfc_pkg::WORD_W-1:0] rd_word;
    logic [NP-1:0]                      rd_valid;
    logic [NP-1:0]                      rd_pop;
    logic [NP-1:0]                      sel_r;
    logic [NP-1:0]                      addr_hit;
    logic [NP-1:0]                      flushing;
    logic [rfc_pkg::REG_W-1:0]          reg_rdata_nxt;
    logic [DW-1:0]                      rdb_nxt;
    logic                               rsop_nxt;
    logic                               reop_nxt;
    logic                               rval_nxt;

    assign pin_nxt = ((s2_r ~^ s3_r) & s2_r) | ((s2_r ^ s3_r) & pin_r);

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            s1_r  <= PIN_IDLE;
            s2_r  <= PIN_IDLE;
            s3_r  <= PIN_IDLE;
            pin_r <= PIN_IDLE;
        end
        else
        begin
            s1_r  <= {read_enable_n, read_start_strobe, poll_address_bus};
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            pin_r <= pin_nxt;
        end
    end

    assign sys_addr   = pin_r[rfc_pkg::REG_W-1:0];
    assign sys_strobe = pin_r[rfc_pkg::REG_W];
    assign sys_ren_n  = pin_r[rfc_pkg::REG_W+1];
    // Selection is taken with enable high or with the start strobe
    assign sel_evt    = sys_ren_n | sys_strobe;

    assign reg_port  = reg_addr[rfc_pkg::PORT_LSB +: PORT_W_L];
    assign reg_local = reg_addr & ~rfc_pkg::PORT_MASK;

    genvar p;
    generate
        for (p = 0; p < NP; p++)
        begin : g_port
            rfc_pkg::rfc_state_type st_r;
            logic                          flush_r;
            logic [TW-1:0]                 af_r;
            logic [TW-1:0]                 ae_r;
            logic [rfc_pkg::REG_W-1:0]     paddr_r;
            logic                          ovf_r;
            logic                          oie_r;
            logic [DW-1:0]                 abc_r;
            logic [DW-1:0]                 pkt_bytes_r;
            logic [rfc_pkg::PWRUP_W-1:0]   pwr_cnt_r;
            logic [LW-1:0]                 cells_r;
            logic                          wsel;
            logic                          in_ready;
            logic                          take;
            logic                          push;
            logic                          ovf_evt;
            logic [LW-1:0]                 level;
            logic [TW-1:0]                 free_grp;
            logic [TW-1:0]                 used_grp;
            logic                          cell_pop;

            assign wsel = reg_wr && (reg_port == PORT_W_L'(p));

            // Control and level registers hold across a flush
            always_ff @(posedge mclk)
            begin
                if (!nrst)
                begin
                    flush_r <= rfc_pkg::CTRL_RST[rfc_pkg::FLUSH_BIT];
                    af_r    <= rfc_pkg::AF_RST[TW-1:0];
                    ae_r    <= rfc_pkg::AE_RST[TW-1:0];
                    paddr_r <= rfc_pkg::PADDR_RST;
                    oie_r   <= 1'b0;
                end
                else if (wsel)
                begin
                    case (reg_local)
                        rfc_pkg::OFF_CTRL:
                            flush_r <= reg_wdata[rfc_pkg::FLUSH_BIT];
                        rfc_pkg::OFF_AF:    af_r    <= reg_wdata[TW-1:0];
                        rfc_pkg::OFF_AE:    ae_r    <= reg_wdata[TW-1:0];
                        rfc_pkg::OFF_PADDR: paddr_r <= reg_wdata;
                        rfc_pkg::OFF_IEN:
                            oie_r <= reg_wdata[rfc_pkg::OIE_BIT];
                        default:            flush_r <= flush_r;
                    endcase
                end
            end

            // Flush, RAM wake-up, hunt for start, run
            always_ff @(posedge mclk)
            begin
                if (!nrst)
                begin
                    st_r      <= rfc_pkg::st_flush;
                    pwr_cnt_r <= '0;
                end
                else if (flush_r)
                begin
                    st_r      <= rfc_pkg::st_flush;
                    pwr_cnt_r <= '0;
                end
                else
                begin
                    case (st_r)
                        rfc_pkg::st_flush:
                        begin
                            st_r <= rfc_pkg::st_pwrup;
                        end
                        rfc_pkg::st_pwrup:
                        begin
                            pwr_cnt_r <= pwr_cnt_r + 8'h01;
                            if (pwr_cnt_r ==
                                rfc_pkg::PWRUP_W'(rfc_pkg::PWRUP_CYC - 1))
                            begin
                                st_r <= rfc_pkg::st_hunt;
                            end
                        end
                        rfc_pkg::st_hunt:
                        begin
                            if (push)
                            begin
                                st_r <= rfc_pkg::st_run;
                            end
                        end
                        rfc_pkg::st_run:
                        begin
                            if (ovf_evt)
                            begin
                                st_r <= rfc_pkg::st_hunt;
                            end
                        end
                        default: st_r <= rfc_pkg::st_flush;
                    endcase
                end
            end

            // Words are dropped until a start of packet arrives after a flush or an overflow
            assign take = !flush_r && ((st_r == rfc_pkg::st_run) ||
                          (st_r == rfc_pkg::st_hunt && line_sop[p]));
            assign push    = line_valid[p] && take && in_ready;
            assign ovf_evt = line_valid[p] && take && !in_ready;
            assign flushing[p] = flush_r || (st_r == rfc_pkg::st_flush);

            rfc_fifo #(
                .WIDTH (rfc_pkg::WORD_W),
                .DEPTH (rfc_pkg::FIFO_DEPTH)
            ) u_fifo (
                .mclk      (mclk),
                .nrst      (nrst),
                .flush     (flushing[p]),
                .in_valid  (push),
                .in_ready  (in_ready),
                .in_data   ({line_sop[p], line_eop[p], line_data[p]}),
                .out_valid (rd_valid[p]),
                .out_ready (rd_pop[p]),
                .out_data  (rd_word[p]),
                .level     (level)
            );

            // Overflow flag: a new event wins over a clear
            always_ff @(posedge mclk)
            begin
                if (!nrst)
                begin
                    ovf_r <= 1'b0;
                end
                else
                begin
                    ovf_r <= ovf_evt || (ovf_r && !(wsel &&
                             reg_local == rfc_pkg::OFF_STAT &&
                             reg_wdata[rfc_pkg::OVF_BIT]));
                end
            end

            // Aborted byte accounting per stored packet
            always_ff @(posedge mclk)
            begin
                if (!nrst)
                begin
                    abc_r       <= '0;
                    pkt_bytes_r <= '0;
                end
                else if (flushing[p] || ovf_evt)
                begin
                    pkt_bytes_r <= '0;
                end
                else if (push && line_eop[p])
                begin
                    pkt_bytes_r <= '0;
                    if (line_abort[p])
                    begin
                        abc_r <= abc_r + pkt_bytes_r +
                                 DW'(line_bytes[p]);
                    end
                end
                else if (push)
                begin
                    pkt_bytes_r <= pkt_bytes_r + DW'(line_bytes[p]);
                end
            end

            // Complete cells stored, for cell-mode fill status
            assign cell_pop = rd_pop[p] && rd_word[p][rfc_pkg::EOP_POS];
            always_ff @(posedge mclk)
            begin
                if (!nrst || flushing[p])
                begin
                    cells_r <= '0;
                end
                else if (push && line_eop[p] && !cell_pop)
                begin
                    cells_r <= cells_r + 4'h1;
                end
                else if (cell_pop && !(push && line_eop[p]))
                begin
                    cells_r <= cells_r - 4'h1;
                end
            end

            assign used_grp = TW'(level);
            assign free_grp = TW'(rfc_pkg::FIFO_DEPTH) - TW'(level);
            assign almost_full[p] = cell_mode ? !in_ready
                                  : (free_grp <= af_r);
            assign almost_empty[p] = cell_mode
                ? (cells_r <= LW'(ae_r[rfc_pkg::CELL_THR_W-1:0]))
                : (used_grp <= ae_r);
            assign rx_cell_packet_available[p] =
                !flushing[p] && !almost_empty[p];
            assign ram_powerdown[p] = flushing[p];
            assign fifo_irq[p]      = ovf_r && oie_r;
            assign line_ready[p]    = in_ready;

            // Address match; Level 2 uses five bits and 1Fh disables
            assign addr_hit[p] = level2_mode
                ? (sys_addr[rfc_pkg::L2_ADDR_W-1:0] ==
                   paddr_r[rfc_pkg::L2_ADDR_W-1:0] &&
                   paddr_r[rfc_pkg::L2_ADDR_W-1:0] !=
                   rfc_pkg::L2_PORT_OFF)
                : (sys_addr == paddr_r);

            always_ff @(posedge mclk)
            begin
                if (!nrst || flushing[p])
                begin
                    sel_r[p] <= 1'b0;
                end
                else if (sel_evt)
                begin
                    sel_r[p] <= addr_hit[p];
                end
            end

            assign rd_pop[p] = sel_r[p] && !sys_ren_n && !sys_strobe &&
                               rd_valid[p] && !flushing[p];

            always_comb
            begin
                case (reg_local)
                    rfc_pkg::OFF_ABC_B0: port_rdata[p] = abc_r[7:0];
                    rfc_pkg::OFF_ABC_B1: port_rdata[p] = abc_r[15:8];
                    rfc_pkg::OFF_ABC_B2: port_rdata[p] = abc_r[23:16];
                    rfc_pkg::OFF_ABC_B3: port_rdata[p] = abc_r[31:24];
                    rfc_pkg::OFF_CTRL:   port_rdata[p] = {7'h00, flush_r};
                    rfc_pkg::OFF_AF:     port_rdata[p] = {2'h0, af_r};
                    rfc_pkg::OFF_AE:     port_rdata[p] = {2'h0, ae_r};
                    rfc_pkg::OFF_PADDR:  port_rdata[p] = paddr_r;
                    rfc_pkg::OFF_STAT:   port_rdata[p] = {7'h00, ovf_r};
                    rfc_pkg::OFF_IEN:    port_rdata[p] = {7'h00, oie_r};
                    default:             port_rdata[p] = 8'h00;
                endcase
            end
        end
    endgenerate

    // Poll answer: fill status of the addressed port
    assign poll_status = |(addr_hit & rx_cell_packet_available);

    always_comb
    begin
        rdb_nxt  = '0;
        rsop_nxt = 1'b0;
        reop_nxt = 1'b0;
        rval_nxt = 1'b0;
        for (int i = 0; i < NP; i++)
        begin
            if (rd_pop[i])
            begin
                rdb_nxt  = rd_word[i][DW-1:0];
                rsop_nxt = rd_word[i][rfc_pkg::SOP_POS];
                reop_nxt = rd_word[i][rfc_pkg::EOP_POS];
                rval_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            read_data_bus <= '0;
            read_sop      <= 1'b0;
            read_eop      <= 1'b0;
            read_valid    <= 1'b0;
        end
        else
        begin
            read_data_bus <= rdb_nxt;
            read_sop      <= rsop_nxt;
            read_eop      <= reop_nxt;
            read_valid    <= rval_nxt;
        end
    end

    assign reg_rdata_nxt = reg_rd ? port_rdata[reg_port] : 8'h00;

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            reg_rdata <= '0;
        end
        else
        begin
            reg_rdata <= reg_rdata_nxt;
        end
    end

endmodule

// [core/rfc_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides and a flush
`timescale 1ns/100ps
module rfc_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     nrst,
    input  wire logic                     flush,
    // Fill side
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [WIDTH-1:0]         in_data,
    // Drain side
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic      [WIDTH-1:0]         out_data,
    // Occupancy
    output logic      [$clog2(DEPTH):0]   level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wptr_r;
    logic [AW-1:0]    rptr_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_r[rptr_r];
    assign level     = cnt_r;

    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem_r[wptr_r] <= in_data;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst || flush)
        begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r  <= '0;
        end
        else
        begin
            if (push)
            begin
                wptr_r <= wptr_r + AW'(1);
            end
            if (pop)
            begin
                rptr_r <= rptr_r + AW'(1);
            end
            if (push && !pop)
            begin
                cnt_r <= cnt_r + (AW+1)'(1);
            end
            else if (pop && !push)
            begin
                cnt_r <= cnt_r - (AW+1)'(1);
            end
        end
    end

endmodule

// [core/rfc_pkg.sv]
// Shared constants and types for the receive FIFO control block
package rfc_pkg;

    // Structure
    localparam int NUM_PORTS  = 4;
    localparam int PORT_W     = 2;
    localparam int DATA_W     = 32;
    localparam int BYTES_W    = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int LEVEL_W    = 4;
    localparam int WORD_W     = DATA_W + 2;
    localparam int SOP_POS    = DATA_W + 1;
    localparam int EOP_POS    = DATA_W;
    localparam int REG_W      = 8;
    localparam int ADDR_W     = 16;
    localparam int SYNC_W     = 10;

    // Register offsets of the first port
    localparam logic [15:0] OFF_ABC_B0 = 16'h102c;
    localparam logic [15:0] OFF_ABC_B1 = 16'h102d;
    localparam logic [15:0] OFF_ABC_B2 = 16'h102e;
    localparam logic [15:0] OFF_ABC_B3 = 16'h102f;
    localparam logic [15:0] OFF_CTRL   = 16'h1080;
    localparam logic [15:0] OFF_AF     = 16'h1082;
    localparam logic [15:0] OFF_AE     = 16'h1083;
    localparam logic [15:0] OFF_PADDR  = 16'h1084;
    localparam logic [15:0] OFF_STAT   = 16'h1088;
    localparam logic [15:0] OFF_IEN    = 16'h108a;

    // Port copies sit 200h apart; the port index is address bits 10:9
    localparam logic [15:0] PORT_STRIDE = 16'h0200;
    localparam logic [15:0] PORT_MASK   = 16'h0600;
    localparam int          PORT_LSB    = 9;

    // Reset values
    localparam logic [7:0] CTRL_RST  = 8'h01;
    localparam logic [7:0] AF_RST    = 8'h10;
    localparam logic [7:0] AE_RST    = 8'h10;
    localparam logic [7:0] PADDR_RST = 8'h00;

    // Field layout
    localparam int         FLUSH_BIT  = 0;
    localparam int         OVF_BIT    = 0;
    localparam int         OIE_BIT    = 0;
    localparam int         THR_W      = 6;
    localparam int         CELL_THR_W = 2;
    localparam int         L2_ADDR_W  = 5;
    localparam logic [4:0] L2_PORT_OFF = 5'h1f;

    // RAM wake-up time after the flush bit is cleared
    localparam int CLK_NS       = 4;
    localparam int RAM_PWRUP_NS = 40;
    localparam int PWRUP_CYC    = (RAM_PWRUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PWRUP_W      = 8;

    typedef enum logic [1:0] {
        st_flush,
        st_pwrup,
        st_hunt,
        st_run
    } rfc_state_type;

endpackage

// [verif/receive_fifo_control_tb.sv]
// Self-checking bench for the receive FIFO control block
`timescale 1ns/100ps
module receive_fifo_control_tb;
    logic mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic cell_mode = 1'b0, level2_mode = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, poll_address_bus;
    logic [3:0] line_valid = 4'h0, line_sop = 4'h0, line_eop = 4'h0;
    logic [3:0] line_abort = 4'h0, line_ready, almost_full, almost_empty;
    logic [3:0] rx_cell_packet_available, ram_powerdown, fifo_irq;
    logic [3:0][31:0] line_data = '0;
    logic [3:0][2:0] line_bytes = '0;
    logic read_enable_n, read_start_strobe, poll_status, read_valid;
    logic read_sop, read_eop;
    logic [31:0] read_data_bus;
    int err_total = 0, samples_checked = 0;
    rfc_ctrl u_dut (.*);
    rfc_llc_model u_llc (.*);
    always #2 mclk = ~mclk;
    task automatic chk(input logic [31:0] g, e);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk({24'h0, reg_rdata}, {24'h0, e});
    endtask
    task automatic send(input int p, n, input logic ab);
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            line_valid[p] <= 1'b1;
            line_sop[p] <= (i == 0);
            line_eop[p] <= (i == n - 1);
            line_abort[p] <= ab;
            line_bytes[p] <= (i == n - 1) ? 3'h2 : 3'h4;
            line_data[p] <= 32'h5a00_0000 + 32'(i);
        end
        @(posedge mclk);
        line_valid[p] <= 1'b0;
    endtask
    task automatic t_regs;
        rd(16'h1080, 8'h01);
        rd(16'h1282, 8'h10);
        rd(16'h1683, 8'h10);
        rd(16'h1484, 8'h00);
        rd(16'h102e, 8'h00);
        rd(16'h162f, 8'h00);
        rd(16'h1081, 8'h00);
    endtask
    task automatic t_abort;
        send(0, 3, 1'b1);
        rd(16'h102c, 8'h0a);
    endtask
    task automatic t_read;
        int w0;
        w0 = u_llc.words;
        send(1, 2, 1'b0);
        u_llc.fetch(8'h02, 1'b0, 8);
        repeat (6) @(posedge mclk);
        chk(u_llc.words - w0, 2);
        chk(u_llc.last_word, 32'h5a00_0001);
        chk(u_llc.last_eop, 1'b1);
    endtask
    task automatic t_ovf;
        wr(16'h148a, 8'h01);
        wr(16'h1482, 8'h01);
        wr(16'h1483, 8'h00);
        #1 chk(almost_full[2], 1'b0);
        send(2, 10, 1'b0);
        #1 chk(fifo_irq[2], 1'b1);
        chk(almost_full[2], 1'b1);
        chk(rx_cell_packet_available[2], 1'b1);
        @(posedge mclk);
        cell_mode <= 1'b1;
        @(posedge mclk);
        #1 chk(almost_empty[2], 1'b1);
        @(posedge mclk);
        cell_mode <= 1'b0;
        wr(16'h1488, 8'h01);
        #1 chk(fifo_irq[2], 1'b0);
        wr(16'h148a, 8'h00);
        wr(16'h1480, 8'h01);
        #1 chk(rx_cell_packet_available[2], 1'b0);
        rd(16'h1482, 8'h01);
        wr(16'h1480, 8'h00);
    endtask
    task automatic t_l2;
        int w0;
        wr(16'h1684, 8'hff);
        level2_mode <= 1'b1;
        send(3, 1, 1'b0);
        w0 = u_llc.words;
        u_llc.fetch(8'h1f, 1'b1, 6);
        repeat (6) @(posedge mclk);
        chk(u_llc.words - w0, 0);
        level2_mode <= 1'b0;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        t_regs();
        for (int p = 0; p < 4; p++)
        begin
            wr(16'h1084 + 16'(p) * 16'h0200, 8'(p + 1));
            wr(16'h1080 + 16'(p) * 16'h0200, 8'h00);
        end
        repeat (12) @(posedge mclk);
        t_abort();
        t_read();
        t_ovf();
        t_l2();
        conclude();
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_total++;
        conclude();
    end
endmodule

// [verif/rfc_ctrl_checker.sv]
// Port checker for the receive FIFO control block
`timescale 1ns/100ps
module rfc_ctrl_checker (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        nrst,
    // Register writes and modes
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        cell_mode,
    input wire logic        level2_mode,
    // Line side and pins
    input wire logic [3:0]  line_valid,
    input wire logic [3:0]  line_ready,
    input wire logic [7:0]  poll_address_bus,
    input wire logic        poll_status,
    // Status
    input wire logic [3:0]  rx_cell_packet_available,
    input wire logic [3:0]  almost_full,
    input wire logic [3:0]  almost_empty,
    input wire logic [3:0]  ram_powerdown,
    input wire logic [3:0]  fifo_irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_avail;
        rx_cell_packet_available == (~almost_empty & ~ram_powerdown);
    endproperty
    a_avail: assert property (p_avail) else $error("avail wrong");
    property p_wake;
        $fell(ram_powerdown[0]) |-> !rx_cell_packet_available[0] [*8];
    endproperty
    a_wake: assert property (p_wake) else $error("early available");
    property p_cellaf;
        cell_mode |-> almost_full == ~line_ready;
    endproperty
    a_cellaf: assert property (p_cellaf) else $error("cell full wrong");
    property p_l2;
        (level2_mode && poll_address_bus[4:0] == 5'h1f) [*6] |-> !poll_status;
    endproperty
    a_l2: assert property (p_l2) else $error("disabled port polled");
    property p_clr;
        reg_wr && reg_addr == 16'h1488 && reg_wdata[0] && !line_valid[2]
            |=> !fifo_irq[2];
    endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    property p_hold;
        !reg_wr |=> ($past(fifo_irq) & ~fifo_irq) == 4'h0;
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_ienoff;
        reg_wr && reg_addr == 16'h148a && !reg_wdata[0] |=> !fifo_irq[2];
    endproperty
    a_ienoff: assert property (p_ienoff) else $error("irq not masked");
    property p_pd;
        reg_wr && reg_addr == 16'h1480 && reg_wdata[0]
            |=> ram_powerdown[2] && !rx_cell_packet_available[2];
    endproperty
    a_pd: assert property (p_pd) else $error("flush ignored");
endmodule

bind rfc_ctrl rfc_ctrl_checker u_chk (.*);

// [verif/rfc_llc_model.sv]
// Link-layer controller model driving the system pins
`timescale 1ns/100ps
module rfc_llc_model (
    // Clock
    input wire logic        mclk,
    // System pins
    output logic     [7:0]  poll_address_bus,
    output logic            read_enable_n,
    output logic            read_start_strobe,
    input wire logic        read_valid,
    input wire logic        read_eop,
    input wire logic [31:0] read_data_bus
);
    int          words = 0;
    logic [31:0] last_word;
    logic        last_eop;
    initial
    begin
        poll_address_bus  = 8'h00;
        read_enable_n     = 1'b1;
        read_start_strobe = 1'b0;
    end
    always @(posedge mclk)
    begin
        if (read_valid === 1'b1)
        begin
            words     <= words + 1;
            last_word <= read_data_bus;
            last_eop  <= read_eop;
        end
    end
    // Select held past the pin synchroniser, then read n cycles
    task automatic fetch(input logic [7:0] a, input logic stb, input int n);
        @(posedge mclk);
        poll_address_bus  <= a;
        read_enable_n     <= ~stb;
        read_start_strobe <= stb;
        repeat (6) @(posedge mclk);
        read_enable_n     <= 1'b0;
        read_start_strobe <= 1'b0;
        repeat (n) @(posedge mclk);
        read_enable_n     <= 1'b1;
    endtask
endmodule
